// >>> hw/overfreq_prot.sv
// Overfrequency protection element with APB settings and status.
`timescale 1ns/100ps
`default_nettype none

module overfreq_prot #(
   parameter int unsigned MS_CYCLES = overfreq_pkg::MS_CYCLES,
   parameter int unsigned CLK_HZ = overfreq_pkg::CLK_HZ,
   parameter logic [15:0] UN_PEAK = 16'h4000
) (
   input wire logic pclk, // APB clock, 20 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction, high for write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error for unmapped address
   input wire logic sample_valid, // One-cycle strobe of a new voltage sample
   input wire logic [15:0] v_phase, // Sampled phase voltage, signed
   input wire logic [15:0] v_line, // Calculated line-to-line voltage, signed
   input wire logic block_in, // Blocking input, active high
   output logic general_start_out, // General start, active high
   output logic general_trip_out // General trip, active high
);

   overfreq_pkg::state_t s_q;
   overfreq_pkg::state_t d;

   // The period window and the comparison scale follow the clock parameter, so a slower clock keeps the same limits in Hz.
   localparam logic [39:0] SCALE = 40'(64'(CLK_HZ) * 64'd100);
   localparam logic [23:0] PER_LO = 24'(64'(SCALE) / 64'(overfreq_pkg::FREQ_MAX));
   localparam logic [23:0] PER_HI = 24'(64'(SCALE) / 64'(overfreq_pkg::FREQ_MIN));

   logic [15:0] vs;
   logic [15:0] mag;
   logic now_neg;
   logic rise_x;
   logic fall_x;
   logic [23:0] n_rise;
   logic [23:0] n_fall;
   logic [24:0] sum;
   logic [23:0] avg;
   logic [23:0] lim_lo;
   logic [23:0] lim_hi;
   logic half_ok;
   logic valid;
   logic over;
   logic enable;
   logic [39:0] prod;
   logic unmapped;
   logic wr;
   logic [12:0] wf;
   logic [6:0] wu;
   logic [13:0] wdl;

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      d = s_q;

      // Source selection and magnitude tracking.
      vs = s_q.src ? v_line : v_phase;
      mag = vs[15] ? 16'(~vs + 16'h0001) : vs;
      now_neg = vs[15];
      rise_x = sample_valid && s_q.neg && !now_neg;
      fall_x = sample_valid && !s_q.neg && now_neg;

      // Free-running interval counters saturate so a lost signal never wraps into a plausible period.
      d.t_rise = (s_q.t_rise == 24'hFFFFFF) ? s_q.t_rise : 24'(s_q.t_rise + 24'h000001);
      d.t_fall = (s_q.t_fall == 24'hFFFFFF) ? s_q.t_fall : 24'(s_q.t_fall + 24'h000001);
      n_rise = s_q.p_rise;
      n_fall = s_q.p_fall;
      if (rise_x) begin
         n_rise = s_q.t_rise;
         d.t_rise = 24'h000001;
      end
      if (fall_x) begin
         n_fall = s_q.t_fall;
         d.t_fall = 24'h000001;
      end
      d.p_rise = n_rise;
      d.p_fall = n_fall;
      if (sample_valid) begin
         d.neg = now_neg;
         if (mag > s_q.peak) begin
            d.peak = mag;
         end
      end

      sum = {1'b0, n_rise} + {1'b0, n_fall};
      avg = sum[24:1];
      lim_lo = 24'({17'h00000, s_q.ulim} * {8'h00, UN_PEAK});
      lim_hi = 24'({8'h00, s_q.peak} * 24'h000064);
      // The peak of the half cycle just closed decides whether the voltage is high enough.
      half_ok = (lim_hi >= lim_lo);
      valid = (n_rise != 24'h000000) && (n_fall != 24'h000000) && half_ok
         && (avg >= PER_LO) && (avg <= PER_HI);
      prod = 40'({16'h0000, avg} * {27'h0000000, s_q.fstart});
      enable = s_q.on && !block_in;
      over = 1'b0;

      // Measurement step at every zero crossing.
      if (rise_x || fall_x) begin
         d.peak = 16'h0000;
         d.volt_ok = half_ok;
         if (valid) begin
            d.icnt = 3'h0;
            if (s_q.vcnt != overfreq_pkg::VALID_NEED) begin
               d.vcnt = 3'(s_q.vcnt + 3'h1);
            end
            if (d.vcnt == overfreq_pkg::VALID_NEED) begin
               d.fval = 1'b1;
               d.per = avg;
            end
         end else begin
            d.vcnt = 3'h0;
            if (s_q.icnt != overfreq_pkg::INVALID_NEED) begin
               d.icnt = 3'(s_q.icnt + 3'h1);
            end
            if (d.icnt == overfreq_pkg::INVALID_NEED) begin
               d.fval = 1'b0;
               d.per = 24'h000000;
            end
         end
         // Frequency above setting is the same as period times setting below the scale constant.
         over = d.fval && valid && (prod < SCALE);
         if (over) begin
            if (s_q.ocnt != overfreq_pkg::OVER_NEED) begin
               d.ocnt = 3'(s_q.ocnt + 3'h1);
            end
            // The delay runs from the first measurement above setting, so it includes the qualifying time.
            if (!s_q.timing) begin
               d.timing = 1'b1;
               d.ms_cnt = 16'h0000;
               d.ms = 14'h0000;
            end
         end else begin
            d.ocnt = 3'h0;
            d.timing = 1'b0;
         end
      end

      // Millisecond time base of the trip delay.
      if (s_q.timing && d.timing && !(over && !s_q.timing)) begin
         if (s_q.ms_cnt == 16'(MS_CYCLES - 1)) begin
            d.ms_cnt = 16'h0000;
            if (s_q.ms != 14'h3FFF) begin
               d.ms = 14'(s_q.ms + 14'h0001);
            end
         end else begin
            d.ms_cnt = 16'(s_q.ms_cnt + 16'h0001);
         end
      end

      if (!enable) begin
         d.ocnt = 3'h0;
         d.timing = 1'b0;
      end
      d.start = enable && (d.ocnt == overfreq_pkg::OVER_NEED);
      // No lower bound on the delay: settings shorter than the five-crossing qualifying time trip together with start.
      d.trip = d.start && !s_q.only && d.timing && (d.ms >= s_q.dly);

      // -----------------------------------------------------------------
      // APB slave: answer in the first access cycle
      // -----------------------------------------------------------------
      unmapped = !(paddr == overfreq_pkg::CTRL_OFS || paddr == overfreq_pkg::FSTART_OFS
         || paddr == overfreq_pkg::ULIM_OFS || paddr == overfreq_pkg::DELAY_OFS
         || paddr == overfreq_pkg::STATUS_OFS || paddr == overfreq_pkg::PERIOD_OFS);
      wr = psel && penable && pwrite && s_q.pready && !s_q.pslverr;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      if (psel && !penable) begin
         d.pready = 1'b1;
         d.pslverr = unmapped;
         unique case (paddr)
            overfreq_pkg::CTRL_OFS: d.prdata = {29'h00000000, s_q.src, s_q.only, s_q.on};
            overfreq_pkg::FSTART_OFS: d.prdata = {19'h00000, s_q.fstart};
            overfreq_pkg::ULIM_OFS: d.prdata = {25'h0000000, s_q.ulim};
            overfreq_pkg::DELAY_OFS: d.prdata = {18'h00000, s_q.dly};
            overfreq_pkg::STATUS_OFS: d.prdata = {27'h0000000, s_q.timing, s_q.volt_ok, s_q.fval,
               s_q.trip, s_q.start};
            overfreq_pkg::PERIOD_OFS: d.prdata = {8'h00, s_q.per};
            default: d.prdata = 32'h00000000;
         endcase
      end

      // Out-of-range settings are clamped to the nearest end of their range.
      wf = pwdata[12:0];
      if (pwdata[31:13] != 19'h00000 || wf > overfreq_pkg::FREQ_MAX) begin
         wf = overfreq_pkg::FREQ_MAX;
      end else if (wf < overfreq_pkg::FREQ_MIN) begin
         wf = overfreq_pkg::FREQ_MIN;
      end
      wu = pwdata[6:0];
      if (pwdata[31:7] != 25'h0000000 || wu > overfreq_pkg::ULIM_MAX) begin
         wu = overfreq_pkg::ULIM_MAX;
      end else if (wu < overfreq_pkg::ULIM_MIN) begin
         wu = overfreq_pkg::ULIM_MIN;
      end
      wdl = pwdata[13:0];
      if (pwdata[31:14] != 18'h00000 || wdl > overfreq_pkg::DELAY_MAX) begin
         wdl = overfreq_pkg::DELAY_MAX;
      end
      if (wr) begin
         unique case (paddr)
            overfreq_pkg::CTRL_OFS: begin
               d.on = pwdata[overfreq_pkg::CTRL_ON_BIT];
               d.only = pwdata[overfreq_pkg::CTRL_ONLY_BIT];
               d.src = pwdata[overfreq_pkg::CTRL_SRC_BIT];
            end
            overfreq_pkg::FSTART_OFS: d.fstart = wf;
            overfreq_pkg::ULIM_OFS: d.ulim = wu;
            overfreq_pkg::DELAY_OFS: d.dly = wdl;
            default: d.on = s_q.on;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.fstart <= overfreq_pkg::FSTART_RST;
         s_q.ulim <= overfreq_pkg::ULIM_RST;
         s_q.dly <= overfreq_pkg::DELAY_RST;
      end else begin
         s_q <= d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign general_start_out = s_q.start;
   assign general_trip_out = s_q.trip;

endmodule // overfreq_prot

`default_nettype wire

// >>> inc/overfreq_pkg.sv
// Constants, register map and state layout of the overfrequency protection element.
`default_nettype none

package overfreq_pkg;

   // -----------------------------------------------------------------
   // Clock and time base
   // -----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;

   // -----------------------------------------------------------------
   // Measurement qualification counts
   // -----------------------------------------------------------------
   localparam logic [2:0] VALID_NEED = 3'h4;
   localparam logic [2:0] INVALID_NEED = 3'h4;
   localparam logic [2:0] OVER_NEED = 3'h5;

   // Settable frequency range in 0.01 Hz units, and the period window it implies.
   localparam logic [12:0] FREQ_MIN = 13'h0FA0;
   localparam logic [12:0] FREQ_MAX = 13'h1B58;
   localparam logic [39:0] FREQ_SCALE = 40'(64'(CLK_HZ) * 64'd100);
   localparam logic [23:0] PERIOD_MIN = 24'(CLK_HZ / 70);
   localparam logic [23:0] PERIOD_MAX = 24'(CLK_HZ / 40);

   // Voltage threshold in 0.01 Un units, delay in ms.
   localparam logic [6:0] ULIM_MIN = 7'h0A;
   localparam logic [6:0] ULIM_MAX = 7'h64;
   localparam logic [13:0] DELAY_MAX = 14'h2710;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] FSTART_OFS = 8'h04;
   localparam logic [7:0] ULIM_OFS = 8'h08;
   localparam logic [7:0] DELAY_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [7:0] PERIOD_OFS = 8'h14;

   // CTRL fields.
   localparam int CTRL_ON_BIT = 0;
   localparam int CTRL_ONLY_BIT = 1;
   localparam int CTRL_SRC_BIT = 2;

   // Reset values.
   localparam logic [12:0] FSTART_RST = 13'h13EC;
   localparam logic [6:0] ULIM_RST = 7'h2D;
   localparam logic [13:0] DELAY_RST = 14'h00C8;

   typedef struct packed {
      logic on;
      logic only;
      logic src;
      logic [12:0] fstart;
      logic [6:0] ulim;
      logic [13:0] dly;
      logic neg;
      logic [23:0] t_rise;
      logic [23:0] t_fall;
      logic [23:0] p_rise;
      logic [23:0] p_fall;
      logic [15:0] peak;
      logic volt_ok;
      logic [2:0] vcnt;
      logic [2:0] icnt;
      logic fval;
      logic [23:0] per;
      logic [2:0] ocnt;
      logic timing;
      logic [15:0] ms_cnt;
      logic [13:0] ms;
      logic start;
      logic trip;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_t;

endpackage

`default_nettype wire

// >>> tb/relay_logic.sv
// Model of the relay logic that drives blocking and takes start and trip.
`timescale 1ns/100ps
`default_nettype none
module relay_logic (
   input wire logic pclk, // Relay sampling clock
   input wire logic presetn, // Reset, active low
   input wire logic block_req, // Bench request to block
   input wire logic general_start_out, // Start from the element
   input wire logic general_trip_out, // Trip from the element
   output logic block_in, // Blocking level to the element
   output logic trip_seen // A trip with start has been taken
);
   // The logic editor only updates on the clock, so blocking never moves between edges.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_in <= 1'b0;
         trip_seen <= 1'b0;
      end else begin
         block_in <= block_req;
         trip_seen <= trip_seen | (general_trip_out & general_start_out);
      end
   end
endmodule // relay_logic
`default_nettype wire

// >>> tb/overfreq_prot_sva.sv
// Concurrent checks on the ports of the overfrequency protection element.
`timescale 1ns/100ps
`default_nettype none
module overfreq_prot_sva (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [7:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic sample_valid, // Sample strobe
   input wire logic [15:0] v_phase, // Phase voltage
   input wire logic [15:0] v_line, // Line voltage
   input wire logic block_in, // Blocking
   input wire logic general_start_out, // Start
   input wire logic general_trip_out // Trip
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable && pready; endsequence
   // A settings write may drop the outputs a cycle late, so hold checks skip bus traffic.
   sequence s_quiet; !sample_valid && !block_in && !psel && !$past(psel); endsequence
   AST_READY_NEXT: assert property (s_setup |=> s_access) else $error("ready missing after setup");
   AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   AST_MAP_ERROR: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14))
      else $error("error flag does not match map");
   AST_ERROR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("bad read not 0");
   AST_BLOCK_START: assert property (block_in |=> !general_start_out) else $error("start while blocked");
   AST_BLOCK_TRIP: assert property (block_in |=> !general_trip_out) else $error("trip while blocked");
   AST_TRIP_START: assert property (general_trip_out |-> general_start_out) else $error("trip alone");
   AST_START_CROSS: assert property ($rose(general_start_out) |-> $past(sample_valid)) else $error("start off crossing");
   AST_START_HOLD: assert property (general_start_out ##0 s_quiet |=> general_start_out) else $error("start lost");
   AST_TRIP_HOLD: assert property (general_trip_out ##0 s_quiet |=> general_trip_out) else $error("trip lost");
endmodule // overfreq_prot_sva
bind overfreq_prot overfreq_prot_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sample_valid(sample_valid), .v_phase(v_phase), .v_line(v_line), .block_in(block_in),
   .general_start_out(general_start_out), .general_trip_out(general_trip_out));
`default_nettype wire

// >>> tb/tb_overfreq_prot.sv
// Self-checking bench of the overfrequency protection element.
`timescale 1ns/100ps
`default_nettype none
module tb_overfreq_prot;
   localparam int unsigned HALF = 143;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic sample_valid = 1'b0, block_req = 1'b0, neg = 1'b0, block_in, start, trip, seen, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] v_phase = 16'h0000;
   int miscompares = 0, checks_done = 0, cycles = 0, t0, n;
   always #25 pclk = ~pclk;
   overfreq_prot #(.MS_CYCLES(20), .CLK_HZ(20000)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .v_phase(v_phase), .v_line(~v_phase), .block_in(block_in),
      .general_start_out(start), .general_trip_out(trip));
   relay_logic i_relay (.pclk(pclk), .presetn(presetn), .block_req(block_req), .general_start_out(start),
      .general_trip_out(trip), .block_in(block_in), .trip_seen(seen));
   task automatic close_out;
      if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(w, rd, e);
   endtask
   // Each step is one half period of h cycles: a peak sample of the same sign, then a sign change.
   task automatic half(input int unsigned h, input int k);
      repeat (2 * k) begin
         repeat (h / 2 - 1) @(posedge pclk);
         sample_valid <= 1'b1;
         v_phase <= neg ? 16'hC000 : 16'h4000;
         @(posedge pclk);
         sample_valid <= 1'b0;
         repeat (h - h / 2 - 1) @(posedge pclk);
         neg = ~neg;
         sample_valid <= 1'b1;
         v_phase <= neg ? 16'hC000 : 16'h4000;
         @(posedge pclk);
         sample_valid <= 1'b0;
      end
   endtask
   task automatic settle;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic t_regs;
      rchk("ctrl", overfreq_pkg::CTRL_OFS, 32'h0);
      rchk("fstart", overfreq_pkg::FSTART_OFS, 32'(overfreq_pkg::FSTART_RST));
      rchk("ulim", overfreq_pkg::ULIM_OFS, 32'(overfreq_pkg::ULIM_RST));
      rchk("delay", overfreq_pkg::DELAY_OFS, 32'(overfreq_pkg::DELAY_RST));
      apb(1'b1, overfreq_pkg::FSTART_OFS, 32'h00001FFF);
      rchk("fstart hi", overfreq_pkg::FSTART_OFS, 32'(overfreq_pkg::FREQ_MAX));
      apb(1'b1, overfreq_pkg::FSTART_OFS, 32'h00000064);
      rchk("fstart lo", overfreq_pkg::FSTART_OFS, 32'(overfreq_pkg::FREQ_MIN));
      apb(1'b1, overfreq_pkg::ULIM_OFS, 32'h0);
      rchk("ulim lo", overfreq_pkg::ULIM_OFS, 32'(overfreq_pkg::ULIM_MIN));
      apb(1'b1, overfreq_pkg::DELAY_OFS, 32'h00003FFF);
      rchk("delay hi", overfreq_pkg::DELAY_OFS, 32'(overfreq_pkg::DELAY_MAX));
      apb(1'b1, overfreq_pkg::STATUS_OFS, 32'hFFFFFFFF);
      rchk("status ro", overfreq_pkg::STATUS_OFS, 32'h0);
      rchk("unmapped", 8'h18, 32'h0);
      check("unmapped err", 32'(err), 32'h1);
      apb(1'b1, overfreq_pkg::FSTART_OFS, 32'(overfreq_pkg::FSTART_RST));
      apb(1'b1, overfreq_pkg::ULIM_OFS, 32'(overfreq_pkg::ULIM_RST));
      apb(1'b1, overfreq_pkg::DELAY_OFS, 32'(overfreq_pkg::DELAY_RST));
   endtask
   task automatic t_off;
      half(HALF, 4);
      settle();
      check("start off", 32'(start), 32'h0);
      check("trip off", 32'(trip), 32'h0);
      rchk("status off", overfreq_pkg::STATUS_OFS, 32'h0000000C);
      rchk("period", overfreq_pkg::PERIOD_OFS, 32'(2 * HALF));
   endtask
   task automatic t_only_block;
      apb(1'b1, overfreq_pkg::CTRL_OFS, 32'h00000003);
      half(HALF, 3);
      settle();
      check("start only", 32'(start), 32'h1);
      check("trip only", 32'(trip), 32'h0);
      @(posedge pclk);
      block_req <= 1'b1;
      settle();
      check("start blocked", 32'(start), 32'h0);
      @(posedge pclk);
      block_req <= 1'b0;
   endtask
   task automatic t_trip;
      apb(1'b1, overfreq_pkg::CTRL_OFS, 32'h00000001);
      t0 = cycles;
      half(HALF, 3);
      settle();
      check("start on", 32'(start), 32'h1);
      while (cycles - t0 < HALF + 3990) @(posedge pclk);
      @(negedge pclk);
      check("trip early", 32'(trip), 32'h0);
      n = 0;
      while (trip !== 1'b1 && n < 100) begin
         @(negedge pclk);
         n++;
      end
      check("trip late", 32'(trip), 32'h1);
   endtask
   task automatic t_invalid;
      half(300, 1);
      settle();
      check("start clear", 32'(start), 32'h0);
      check("trip taken", 32'(seen), 32'h1);
      apb(1'b0, overfreq_pkg::PERIOD_OFS, 32'h0);
      check("period held", 32'(rd !== 32'h0), 32'h1);
      half(300, 2);
      settle();
      rchk("period zero", overfreq_pkg::PERIOD_OFS, 32'h0);
      rchk("status end", overfreq_pkg::STATUS_OFS, 32'h00000008);
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_off();
      t_only_block();
      t_trip();
      t_invalid();
      close_out();
   end
endmodule // tb_overfreq_prot
`default_nettype wire
